// ==== rtl/scic_top.sv ====
/*
 Command input conditioning of a servo drive: pulse train decoding,
 ratio numerator switching, preset speed select and overtravel inhibit,
 with settings and status over AXI4-Lite.
 Assumes pins synchronous-sampled on MCLK_IN, one AXI master.
*/
// Behaviour
// - Gear switch closed selects second numerator, outside velocity mode only
// - Velocity mode: two selects form speed code
// - Open clockwise limit blocks clockwise torque
// - Open counter-clockwise limit blocks its torque
// - Ignore setting 1 disables both limits
// - Active limit with brake setting 0 brakes
// - Decode quadrature, cw/ccw or step/direction
`timescale 1ns/1ps
`include "scic_consts.svh"
module scic_top (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    // AXI4-Lite write address and data
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [`SCIC_ADDR_W-1:0] AXI_AWADDR_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    // AXI4-Lite write response
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    output logic [1:0] AXI_BRESP_OUT,
    // AXI4-Lite read
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    input wire logic [`SCIC_ADDR_W-1:0] AXI_ARADDR_IN,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    // Host connector, 1 = connected to the common return
    input wire logic STEP_INPUT_POS_IN,
    input wire logic STEP_INPUT_NEG_IN,
    input wire logic DIRECTION_INPUT_POS_IN,
    input wire logic DIRECTION_INPUT_NEG_IN,
    input wire logic PRESET_SPEED_SELECT_BIT0_IN,
    input wire logic PRESET_SPEED_SELECT_BIT1_IN,
    input wire logic CLOCKWISE_LIMIT_INPUT_IN,
    input wire logic COUNTER_CLOCKWISE_LIMIT_INPUT_IN,
    // Drive side
    output logic COUNT_UP_OUT,
    output logic COUNT_DOWN_OUT,
    output logic [15:0] RATIO_NUMERATOR_OUT,
    output logic [1:0] PRESET_SPEED_CODE_OUT,
    output logic CW_TORQUE_INHIBIT_OUT,
    output logic CCW_TORQUE_INHIBIT_OUT,
    output logic DYNAMIC_BRAKE_OUT
);
    scic_pkg::scic_pins_t raw;
    scic_pkg::scic_pins_t flt;
    scic_pkg::scic_cfg_t cfg;
    logic line_a, line_b, a_q, b_q, quad_x, quad_y;
    logic next_up, next_down, gear2, honour, cw_inh, ccw_inh;
    logic [31:0] position;
    logic [31:0] rd_word;
    logic aw_got, w_got, wr_fire;
    logic [`SCIC_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] ctrl_m;

    function automatic logic rise(input logic now, input logic old);
        return now & ~old;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [`SCIC_ADDR_W-1:0] a);
        return a == `SCIC_OFS_CTRL || a == `SCIC_OFS_NUM1 ||
            a == `SCIC_OFS_NUM2 || a == `SCIC_OFS_STAT ||
            a == `SCIC_OFS_POS;
    endfunction

    function automatic logic [31:0] ctrl_word(
            input scic_pkg::scic_cfg_t c);
        logic [31:0] w;
        w = 32'h00000000;
        w[`SCIC_CTRL_FMT_LSB +: 2] = c.pulse_format_setting;
        w[`SCIC_CTRL_IGN_BIT] = c.overtravel_ignore_setting;
        w[`SCIC_CTRL_BRK_BIT] = c.overtravel_brake_setting;
        w[`SCIC_CTRL_VEL_BIT] = c.velocity_mode;
        return w;
    endfunction

    assign raw = {STEP_INPUT_POS_IN, STEP_INPUT_NEG_IN,
        DIRECTION_INPUT_POS_IN, DIRECTION_INPUT_NEG_IN,
        PRESET_SPEED_SELECT_BIT0_IN, PRESET_SPEED_SELECT_BIT1_IN,
        CLOCKWISE_LIMIT_INPUT_IN, COUNTER_CLOCKWISE_LIMIT_INPUT_IN};

    scic_input_filter u_filter (
        .clk_in(MCLK_IN),
        .reset_in(RESET_IN),
        .raw_in(raw),
        .flt_out(flt)
    );

    // Differential pair reads active when the positive leg alone is high
    assign line_a = flt.step_input_pos & ~flt.step_input_neg;
    assign line_b = flt.direction_input_pos & ~flt.direction_input_neg;
    assign quad_x = line_a ^ b_q;
    assign quad_y = line_b ^ a_q;
    assign gear2 = ~cfg.velocity_mode & flt.preset_speed_select_bit0;
    assign honour = ~cfg.overtravel_ignore_setting;
    assign cw_inh = honour & ~flt.clockwise_limit_input;
    assign ccw_inh = honour & ~flt.counter_clockwise_limit_input;

    always_comb begin
        next_up = 1'b0;
        next_down = 1'b0;
        unique case (cfg.pulse_format_setting)
            scic_pkg::FMT_QUAD: begin
                next_up = quad_x & ~quad_y;
                next_down = quad_y & ~quad_x;
            end
            scic_pkg::FMT_CWCCW: begin
                next_up = rise(line_a, a_q) & ~rise(line_b, b_q);
                next_down = rise(line_b, b_q) & ~rise(line_a, a_q);
            end
            scic_pkg::FMT_STEPDIR: begin
                next_up = rise(line_a, a_q) & ~line_b;
                next_down = rise(line_a, a_q) & line_b;
            end
            scic_pkg::FMT_RSVD: begin
            end
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            COUNT_UP_OUT <= 1'b0;
            COUNT_DOWN_OUT <= 1'b0;
            position <= 32'h00000000;
        end else begin
            a_q <= line_a;
            b_q <= line_b;
            COUNT_UP_OUT <= next_up;
            COUNT_DOWN_OUT <= next_down;
            if (next_up) begin
                position <= position + 32'h00000001;
            end else if (next_down) begin
                position <= position - 32'h00000001;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            RATIO_NUMERATOR_OUT <= `SCIC_RST_NUM;
            PRESET_SPEED_CODE_OUT <= 2'h0;
            CW_TORQUE_INHIBIT_OUT <= 1'b0;
            CCW_TORQUE_INHIBIT_OUT <= 1'b0;
            DYNAMIC_BRAKE_OUT <= 1'b0;
        end else begin
            RATIO_NUMERATOR_OUT <= gear2 ? cfg.second_ratio_numerator :
                cfg.first_ratio_numerator;
            PRESET_SPEED_CODE_OUT <= cfg.velocity_mode ?
                {flt.preset_speed_select_bit1,
                 flt.preset_speed_select_bit0} : 2'h0;
            CW_TORQUE_INHIBIT_OUT <= cw_inh;
            CCW_TORQUE_INHIBIT_OUT <= ccw_inh;
            DYNAMIC_BRAKE_OUT <= (cw_inh | ccw_inh) &
                ~cfg.overtravel_brake_setting;
        end
    end

    // Write path: address and data taken in either order
    assign wr_fire = aw_got & w_got & ~AXI_BVALID_OUT;

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            AXI_AWREADY_OUT <= 1'b0;
            aw_got <= 1'b0;
            wr_addr <= '0;
        end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
            AXI_AWREADY_OUT <= 1'b0;
            aw_got <= 1'b1;
            wr_addr <= AXI_AWADDR_IN;
        end else if (wr_fire) begin
            aw_got <= 1'b0;
        end else if (!aw_got && !AXI_BVALID_OUT) begin
            AXI_AWREADY_OUT <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            AXI_WREADY_OUT <= 1'b0;
            w_got <= 1'b0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
            AXI_WREADY_OUT <= 1'b0;
            w_got <= 1'b1;
            wr_data <= AXI_WDATA_IN;
            wr_strb <= AXI_WSTRB_IN;
        end else if (wr_fire) begin
            w_got <= 1'b0;
        end else if (!w_got && !AXI_BVALID_OUT) begin
            AXI_WREADY_OUT <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            AXI_BVALID_OUT <= 1'b0;
            AXI_BRESP_OUT <= `SCIC_RESP_OKAY;
        end else if (wr_fire) begin
            AXI_BVALID_OUT <= 1'b1;
            AXI_BRESP_OUT <= mapped(wr_addr) ? `SCIC_RESP_OKAY :
                `SCIC_RESP_DECERR;
        end else if (AXI_BREADY_IN) begin
            AXI_BVALID_OUT <= 1'b0;
        end
    end

    // Settings; status and position words ignore writes
    assign ctrl_m = merge(ctrl_word(cfg), wr_data, wr_strb);

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            cfg.pulse_format_setting <= scic_pkg::scic_fmt_t'(`SCIC_RST_FMT);
            cfg.overtravel_ignore_setting <= `SCIC_RST_IGNORE;
            cfg.overtravel_brake_setting <= `SCIC_RST_BRAKE;
            cfg.velocity_mode <= `SCIC_RST_VEL;
            cfg.first_ratio_numerator <= `SCIC_RST_NUM;
            cfg.second_ratio_numerator <= `SCIC_RST_NUM;
        end else if (wr_fire && wr_addr == `SCIC_OFS_CTRL) begin
            cfg.pulse_format_setting <=
                scic_pkg::scic_fmt_t'(ctrl_m[`SCIC_CTRL_FMT_LSB +: 2]);
            cfg.overtravel_ignore_setting <= ctrl_m[`SCIC_CTRL_IGN_BIT];
            cfg.overtravel_brake_setting <= ctrl_m[`SCIC_CTRL_BRK_BIT];
            cfg.velocity_mode <= ctrl_m[`SCIC_CTRL_VEL_BIT];
        end else if (wr_fire && wr_addr == `SCIC_OFS_NUM1) begin
            cfg.first_ratio_numerator <= 16'(merge(
                {16'h0000, cfg.first_ratio_numerator},
                wr_data, wr_strb));
        end else if (wr_fire && wr_addr == `SCIC_OFS_NUM2) begin
            cfg.second_ratio_numerator <= 16'(merge(
                {16'h0000, cfg.second_ratio_numerator},
                wr_data, wr_strb));
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        unique case (AXI_ARADDR_IN)
            `SCIC_OFS_CTRL: rd_word = ctrl_word(cfg);
            `SCIC_OFS_NUM1: rd_word[15:0] = cfg.first_ratio_numerator;
            `SCIC_OFS_NUM2: rd_word[15:0] = cfg.second_ratio_numerator;
            `SCIC_OFS_STAT: begin
                rd_word[`SCIC_STAT_PINS_LSB +: 8] = flt;
                rd_word[`SCIC_STAT_GEAR_BIT] = gear2;
                rd_word[`SCIC_STAT_SPD_LSB +: 2] = PRESET_SPEED_CODE_OUT;
                rd_word[`SCIC_STAT_CWI_BIT] = CW_TORQUE_INHIBIT_OUT;
                rd_word[`SCIC_STAT_CCWI_BIT] = CCW_TORQUE_INHIBIT_OUT;
                rd_word[`SCIC_STAT_DB_BIT] = DYNAMIC_BRAKE_OUT;
            end
            `SCIC_OFS_POS: rd_word = position;
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            AXI_ARREADY_OUT <= 1'b0;
            AXI_RVALID_OUT <= 1'b0;
            AXI_RDATA_OUT <= 32'h00000000;
            AXI_RRESP_OUT <= `SCIC_RESP_OKAY;
        end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
            AXI_ARREADY_OUT <= 1'b0;
            AXI_RVALID_OUT <= 1'b1;
            AXI_RDATA_OUT <= rd_word;
            AXI_RRESP_OUT <= mapped(AXI_ARADDR_IN) ? `SCIC_RESP_OKAY :
                `SCIC_RESP_DECERR;
        end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
            AXI_RVALID_OUT <= 1'b0;
        end else if (!AXI_RVALID_OUT) begin
            AXI_ARREADY_OUT <= 1'b1;
        end
    end

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);

    AST_GEAR_SECOND: assert property (
        gear2 |=> RATIO_NUMERATOR_OUT == $past(cfg.second_ratio_numerator))
        else $error("second numerator not applied");
    AST_SPEED_CODE: assert property (
        cfg.velocity_mode |=> PRESET_SPEED_CODE_OUT ==
        $past({flt.preset_speed_select_bit1, flt.preset_speed_select_bit0}))
        else $error("speed code does not follow selects");
    AST_CW_BLOCK: assert property (
        (honour && !flt.clockwise_limit_input) |=> CW_TORQUE_INHIBIT_OUT)
        else $error("clockwise torque not blocked");
    AST_CCW_BLOCK: assert property (
        (honour && !flt.counter_clockwise_limit_input)
        |=> CCW_TORQUE_INHIBIT_OUT)
        else $error("counter-clockwise torque not blocked");
    AST_IGNORE: assert property (
        cfg.overtravel_ignore_setting |=> !CW_TORQUE_INHIBIT_OUT &&
        !CCW_TORQUE_INHIBIT_OUT && !DYNAMIC_BRAKE_OUT)
        else $error("limits acted while ignored");
    AST_BRAKE: assert property (
        ##1 DYNAMIC_BRAKE_OUT == ((CW_TORQUE_INHIBIT_OUT ||
        CCW_TORQUE_INHIBIT_OUT) && !$past(cfg.overtravel_brake_setting)))
        else $error("dynamic brake disagrees with limits");
    AST_QUAD_DIR: assert property (
        (cfg.pulse_format_setting == scic_pkg::FMT_QUAD && !a_q && !b_q
        && line_a && !line_b) |=> COUNT_UP_OUT && !COUNT_DOWN_OUT)
        else $error("quadrature step not counted up");
    AST_STEP_SIGN: assert property (
        (cfg.pulse_format_setting == scic_pkg::FMT_STEPDIR && line_a &&
        !a_q && line_b) |=> COUNT_DOWN_OUT &&
        position == $past(position) - 32'h00000001)
        else $error("step with sign high not counted down");

    COV_QUAD_UP: cover property (
        cfg.pulse_format_setting == scic_pkg::FMT_QUAD ##1 COUNT_UP_OUT);
    COV_CCW_PULSE: cover property (
        cfg.pulse_format_setting == scic_pkg::FMT_CWCCW ##1 COUNT_DOWN_OUT);
    COV_BRAKE: cover property (DYNAMIC_BRAKE_OUT);
    COV_GEAR2: cover property (gear2 && COUNT_UP_OUT);

endmodule

// ==== rtl/scic_consts.svh ====
/*
 Offsets, field positions, reset values and timing counts of the servo
 command input conditioning block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SCIC_CONSTS_SVH
`define SCIC_CONSTS_SVH

// Register bus
`define SCIC_ADDR_W 8
`define SCIC_OFS_CTRL 8'h00
`define SCIC_OFS_NUM1 8'h04
`define SCIC_OFS_NUM2 8'h08
`define SCIC_OFS_STAT 8'h0c
`define SCIC_OFS_POS 8'h10
`define SCIC_RESP_OKAY 2'h0
`define SCIC_RESP_DECERR 2'h3

// Control word fields
`define SCIC_CTRL_FMT_LSB 0
`define SCIC_CTRL_IGN_BIT 2
`define SCIC_CTRL_BRK_BIT 3
`define SCIC_CTRL_VEL_BIT 4

// Status word fields
`define SCIC_STAT_PINS_LSB 0
`define SCIC_STAT_GEAR_BIT 8
`define SCIC_STAT_SPD_LSB 9
`define SCIC_STAT_CWI_BIT 11
`define SCIC_STAT_CCWI_BIT 12
`define SCIC_STAT_DB_BIT 13

// Reset values
`define SCIC_RST_FMT 2'h0
`define SCIC_RST_IGNORE 1'h1
`define SCIC_RST_BRAKE 1'h0
`define SCIC_RST_VEL 1'h0
`define SCIC_RST_NUM 16'h0001

// Timing
`define SCIC_CLK_MHZ 250
`define SCIC_FILT_NS 16
`define SCIC_FILT_CYC ((`SCIC_FILT_NS * `SCIC_CLK_MHZ + 999) / 1000)
`define SCIC_FILT_CNT_W 3

`endif

// ==== rtl/scic_pkg.sv ====
/*
 Types of the servo command input conditioning block.
 Assumes nothing of its surroundings.
*/
package scic_pkg;

    typedef enum logic [1:0] {
        FMT_QUAD,
        FMT_CWCCW,
        FMT_STEPDIR,
        FMT_RSVD
    } scic_fmt_t;

    // Host connector levels, 1 = connected to the common return
    typedef struct packed {
        logic step_input_pos;
        logic step_input_neg;
        logic direction_input_pos;
        logic direction_input_neg;
        logic preset_speed_select_bit0;
        logic preset_speed_select_bit1;
        logic clockwise_limit_input;
        logic counter_clockwise_limit_input;
    } scic_pins_t;

    typedef struct packed {
        scic_fmt_t pulse_format_setting;
        logic overtravel_ignore_setting;
        logic overtravel_brake_setting;
        logic velocity_mode;
        logic [15:0] first_ratio_numerator;
        logic [15:0] second_ratio_numerator;
    } scic_cfg_t;

endpackage

// ==== rtl/scic_input_filter.sv ====
/*
 Two-flop synchroniser and per-bit deglitch filter for the host pins.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "scic_consts.svh"
module scic_input_filter (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pins
    input wire scic_pkg::scic_pins_t raw_in,
    output scic_pkg::scic_pins_t flt_out
);
    localparam int W = $bits(scic_pkg::scic_pins_t);
    localparam logic [`SCIC_FILT_CNT_W-1:0] FILT_LAST =
        `SCIC_FILT_CNT_W'(`SCIC_FILT_CYC - 1);

    logic [W-1:0] meta;
    logic [W-1:0] stage2;
    logic [W-1:0] filt;
    logic [`SCIC_FILT_CNT_W-1:0] cnt [W];

    assign flt_out = scic_pkg::scic_pins_t'(filt);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            meta <= '0;
            stage2 <= '0;
            filt <= '0;
            for (int i = 0; i < W; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            meta <= raw_in;
            stage2 <= meta;
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == filt[i]) begin
                    cnt[i] <= '0;
                end else if (cnt[i] == FILT_LAST) begin
                    filt[i] <= stage2[i];
                    cnt[i] <= '0;
                end else begin
                    cnt[i] <= cnt[i] + `SCIC_FILT_CNT_W'(1);
                end
            end
        end
    end

    AST_FILTER_HOLD: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ((filt ^ $past(filt)) & ($past(stage2, 1) ^ filt)) == '0 &&
        ((filt ^ $past(filt)) & ($past(stage2, 4) ^ filt)) == '0)
        else $error("filtered pin changed without a stable sample run");

endmodule

// ==== dv/scic_host_model.sv ====
/*
 Host motion controller model: command pulse lines and switch contacts.
 Assumes the bench calls its tasks one at a time, from the clock domain.
*/
`timescale 1ns/1ps
module scic_host_model #(
    // 250 cycles of 4 ns per edge, at most 500 kpps
    parameter int HALF_CYC = 250
) (
    input wire logic clk_in,
    output scic_pkg::scic_pins_t pins_out
);
    logic step_on = 1'b0;
    logic dir_on = 1'b0;
    logic [3:0] sw = 4'hf;
    int ph = 0;

    // Line driver: both halves always driven, opposite
    always_comb begin
        pins_out = {step_on, ~step_on, dir_on, ~dir_on, sw};
    end

    task automatic set_switches(input logic [3:0] s);
        @(posedge clk_in);
        sw <= s;
    endtask

    task automatic line_edge(input bit on_dir, input logic lvl);
        repeat (HALF_CYC) @(posedge clk_in);
        if (on_dir) dir_on <= lvl;
        else step_on <= lvl;
    endtask

    task automatic pulse(input bit on_dir);
        line_edge(on_dir, 1'b1);
        line_edge(on_dir, 1'b0);
    endtask

    // Phase order {step, direction}: 00 10 11 01 is forward
    task automatic quad(input int steps);
        logic [1:0] seq [4];
        seq = '{2'b00, 2'b10, 2'b11, 2'b01};
        for (int i = 0; i < (steps < 0 ? -steps : steps); i++) begin
            ph = (steps < 0) ? (ph + 3) % 4 : (ph + 1) % 4;
            repeat (HALF_CYC) @(posedge clk_in);
            {step_on, dir_on} <= seq[ph];
        end
    endtask

    // Short spike on the step line
    task automatic glitch(input int len);
        repeat (HALF_CYC) @(posedge clk_in);
        step_on <= 1'b1;
        repeat (len) @(posedge clk_in);
        step_on <= 1'b0;
    endtask
endmodule

// ==== dv/scic_top_test.sv ====
/*
 Self-checking bench of the command input conditioning block.
 Assumes the host model drives every connector pin.
*/
`timescale 1ns/1ps
`include "scic_consts.svh"
module scic_top_test;
    typedef struct packed {
        logic [4:0] ctrl;
        logic [3:0] sw;
        logic gear;
        logic [1:0] spd;
        logic [2:0] inh;
    } scic_row_t;
    localparam int TIMEOUT_CYC = 30000;
    localparam logic [15:0] NUM1 = 16'h0123;
    localparam logic [15:0] NUM2 = 16'h0456;
    // Switches {bit0, bit1, cw, ccw}, inhibits {cw, ccw, brake}
    localparam scic_row_t ROWS [8] = '{
        '{5'h04, 4'h8, 1'b1, 2'h0, 3'h0}, '{5'h00, 4'h1, 1'b0, 2'h0, 3'h5},
        '{5'h08, 4'h2, 1'b0, 2'h0, 3'h2}, '{5'h10, 4'hb, 1'b0, 2'h1, 3'h0},
        '{5'h10, 4'h7, 1'b0, 2'h2, 3'h0}, '{5'h10, 4'hf, 1'b0, 2'h3, 3'h0},
        '{5'h00, 4'hf, 1'b1, 2'h0, 3'h0}, '{5'h08, 4'h8, 1'b1, 2'h0, 3'h6}};
    localparam int EXP_UP [4] = '{5, 4, 3, 0};
    localparam int EXP_DN [4] = '{1, 1, 1, 0};
    localparam logic [1:0] OK = `SCIC_RESP_OKAY;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [`SCIC_ADDR_W-1:0] awaddr = 8'h00;
    logic [`SCIC_ADDR_W-1:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, spd;
    logic [31:0] rdata;
    logic cnt_up, cnt_dn, cw_inh, ccw_inh, brake;
    logic [15:0] ratio;
    scic_pkg::scic_pins_t pins;
    int ups = 0, downs = 0, cycles = 0, bad_count = 0, check_count = 0;

    always #2 clk = ~clk;

    scic_host_model host_u (.clk_in(clk), .pins_out(pins));

    scic_top dut_u (
        .MCLK_IN(clk), .RESET_IN(rst),
        .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
        .AXI_AWADDR_IN(awaddr), .AXI_WVALID_IN(wvalid),
        .AXI_WREADY_OUT(wready), .AXI_WDATA_IN(wdata),
        .AXI_WSTRB_IN(4'hf), .AXI_BVALID_OUT(bvalid),
        .AXI_BREADY_IN(bready), .AXI_BRESP_OUT(bresp),
        .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
        .AXI_ARADDR_IN(araddr), .AXI_RVALID_OUT(rvalid),
        .AXI_RREADY_IN(rready), .AXI_RDATA_OUT(rdata),
        .AXI_RRESP_OUT(rresp),
        .STEP_INPUT_POS_IN(pins.step_input_pos),
        .STEP_INPUT_NEG_IN(pins.step_input_neg),
        .DIRECTION_INPUT_POS_IN(pins.direction_input_pos),
        .DIRECTION_INPUT_NEG_IN(pins.direction_input_neg),
        .PRESET_SPEED_SELECT_BIT0_IN(pins.preset_speed_select_bit0),
        .PRESET_SPEED_SELECT_BIT1_IN(pins.preset_speed_select_bit1),
        .CLOCKWISE_LIMIT_INPUT_IN(pins.clockwise_limit_input),
        .COUNTER_CLOCKWISE_LIMIT_INPUT_IN(
            pins.counter_clockwise_limit_input),
        .COUNT_UP_OUT(cnt_up), .COUNT_DOWN_OUT(cnt_dn),
        .RATIO_NUMERATOR_OUT(ratio), .PRESET_SPEED_CODE_OUT(spd),
        .CW_TORQUE_INHIBIT_OUT(cw_inh), .CCW_TORQUE_INHIBIT_OUT(ccw_inh),
        .DYNAMIC_BRAKE_OUT(brake));

    // Pulse counting and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cnt_up === 1'b1) ups <= ups + 1;
        if (cnt_dn === 1'b1) downs <= downs + 1;
        if (cycles == TIMEOUT_CYC) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] e);
        check_count++;
        if (got !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] e);
        check_count++;
        if (got !== e) begin
            bad_count++;
            $display("ERROR t=%0t resp got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr_check(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, r);
        check_resp(r, er);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] e,
                            input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check_word(d, e);
        check_resp(r, er);
    endtask

    initial begin
        logic [31:0] p0, p1, d;
        logic [1:0] r;
        int u0, d0;
        scic_row_t row;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_check(`SCIC_OFS_CTRL, 32'h4, OK);
        rd_check(`SCIC_OFS_NUM2, 32'h1, OK);
        check_word({29'h0, cw_inh, ccw_inh, brake}, 32'h0);
        rd_check(8'h14, 32'h0, `SCIC_RESP_DECERR);
        wr_check(8'h14, 32'h1, `SCIC_RESP_DECERR);
        wr_check(`SCIC_OFS_NUM1, {16'hbeef, NUM1}, OK);
        wr_check(`SCIC_OFS_NUM2, {16'h0, NUM2}, OK);
        rd_check(`SCIC_OFS_NUM1, {16'h0, NUM1}, OK);
        $display("Test registers done");
        for (int i = 0; i < 8; i++) begin
            row = ROWS[i];
            wr_check(`SCIC_OFS_CTRL, {27'h0, row.ctrl}, OK);
            host_u.set_switches(row.sw);
            repeat (12) @(posedge clk);
            #1;
            check_word({16'h0, ratio},
                {16'h0, row.gear ? NUM2 : NUM1});
            check_word({30'h0, spd}, {30'h0, row.spd});
            check_word({29'h0, cw_inh, ccw_inh, brake},
                {29'h0, row.inh});
            axi_read(`SCIC_OFS_STAT, d, r);
            check_word({26'h0, d[13:8]}, {26'h0, row.inh[0], row.inh[1],
                row.inh[2], row.spd, row.gear});
            check_word({24'h0, d[7:0]}, {24'h0, 4'h5, row.sw});
            $display("Test row %0d done", i);
        end
        for (int f = 0; f < 4; f++) begin
            wr_check(`SCIC_OFS_CTRL, 32'h4 | 32'(f), OK);
            axi_read(`SCIC_OFS_POS, p0, r);
            #1;
            u0 = ups;
            d0 = downs;
            if (f == 0) begin
                host_u.quad(5);
                host_u.quad(-1);
            end else begin
                repeat (3) host_u.pulse(1'b0);
                host_u.line_edge(1'b1, 1'b1);
                host_u.pulse(1'b0);
                host_u.line_edge(1'b1, 1'b0);
            end
            repeat (20) @(posedge clk);
            axi_read(`SCIC_OFS_POS, p1, r);
            check_word(32'(ups - u0), 32'(EXP_UP[f]));
            check_word(32'(downs - d0), 32'(EXP_DN[f]));
            check_word(p1 - p0, 32'(EXP_UP[f] - EXP_DN[f]));
            $display("Test format %0d done", f);
        end
        wr_check(`SCIC_OFS_POS, 32'hffff_ffff, OK);
        rd_check(`SCIC_OFS_POS, p1, OK);
        wr_check(`SCIC_OFS_CTRL, 32'h6, OK);
        #1;
        u0 = ups;
        host_u.glitch(3);
        repeat (20) @(posedge clk);
        #1;
        check_word(32'(ups - u0), 32'h0);
        $display("Test glitch done");
        // Mid-run reset brings settings and outputs back to defaults
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check_word({16'h0, ratio}, 32'h1);
        check_word({30'h0, spd}, 32'h0);
        check_word({29'h0, cw_inh, ccw_inh, brake}, 32'h0);
        rd_check(`SCIC_OFS_CTRL, 32'h4, OK);
        rd_check(`SCIC_OFS_NUM1, 32'h1, OK);
        $display("Test reset done");
        report_and_stop();
    end
endmodule
